// File: verilog/dce_pkg.sv
// Purpose: Shared constants for the dual 8-bit cascadable event timer.
// Assumes: APB register access, one 32-bit word per register.
// Notes: Register offsets are byte addresses.
package dce_pkg;

    localparam int ADDR_W = 12;
    localparam int PRE_W = 12;

    // Register byte offsets
    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_CLKSEL = 12'h004;
    localparam logic [11:0] OFS_WAVE = 12'h008;
    localparam logic [11:0] OFS_OSC = 12'h00c;
    localparam logic [11:0] OFS_LO_CMP = 12'h010;
    localparam logic [11:0] OFS_HI_CMP = 12'h014;
    localparam logic [11:0] OFS_COUNT = 12'h018;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h01c;
    localparam logic [11:0] OFS_IRQ_EN = 12'h020;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h024;

    // Field positions
    localparam int MODE_LO_EN_BIT = 0;
    localparam int MODE_HI_EN_BIT = 1;
    localparam int MODE_CASCADE_BIT = 2;
    localparam int WAVE_A_EN_BIT = 0;
    localparam int WAVE_B_EN_BIT = 4;
    localparam int OSC_MODE_BIT = 0;
    localparam int IRQ_LO_BIT = 0;
    localparam int IRQ_HI_BIT = 1;

    // Reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [7:0] CLKSEL_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic OSC_RST = 1'b0;
    localparam logic [1:0] IRQ_RST = 2'h0;

    // Clock-select codes
    localparam logic [3:0] CODE_EXT_FALL = 4'h0;
    localparam logic [3:0] CODE_EXT_RISE = 4'h1;
    localparam logic [3:0] CODE_INT_FIRST = 4'h6;
    localparam logic [3:0] CODE_INT_LAST = 4'hf;
    // Exponent offset of codes 6..14 and exponent of code 15 (fast base)
    localparam logic [3:0] CODE_EXP_OFFSET = 4'h5;
    localparam logic [3:0] CODE_LAST_EXP = 4'hb;

endpackage : dce_pkg

// File: verilog/dce_edge_sync.sv
// Purpose: Synchronise an event pin and report its filtered edges.
// Assumes: Pin is asynchronous to ref_clk_i.
// Notes: A level change counts once stages two and three agree.
`timescale 1ns/10ps
module dce_edge_sync (
    input wire logic ref_clk_i, // Main clock
    input wire logic rst_n_i,   // Async reset, active low
    input wire logic pin_i,     // Raw event pin
    output logic rise_o,        // One-cycle pulse on accepted rising edge
    output logic fall_o         // One-cycle pulse on accepted falling edge
);
    logic [2:0] sync_reg;
    logic level_reg;

    // Stage one feeds stage two only
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_reg <= 3'h0;
        end else begin
            sync_reg <= {sync_reg[1:0], pin_i};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_reg <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            if (sync_reg[1] == sync_reg[2] && sync_reg[1] != level_reg) begin
                level_reg <= sync_reg[1];
                rise_o <= sync_reg[1];
                fall_o <= ~sync_reg[1];
            end
        end
    end

endmodule : dce_edge_sync

// File: verilog/dce_timer.sv
// Purpose: Two 8-bit event/interval counters, cascadable to 16 bits.
// Assumes: APB slave, ref_clk_i is the main clock, zero-wait answers.
// Notes: Counters clear on the count tick after reaching their compare.
`timescale 1ns/10ps
module dce_timer
    import dce_pkg::*;
(
    input wire logic ref_clk_i,            // Main clock, 40 MHz
    input wire logic rst_n_i,              // Async reset, active low
    input wire logic psel_i,               // APB select
    input wire logic penable_i,            // APB enable
    input wire logic pwrite_i,             // APB direction
    input wire logic [ADDR_W-1:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i,      // APB write data
    output logic [31:0] prdata_o,          // APB read data
    output logic pready_o,                 // APB ready
    output logic pslverr_o,                // APB error, unmapped address
    input wire logic event_input_a_i,      // Event pin for low counter
    input wire logic event_input_b_i,      // Event pin for high counter
    output logic wave_output_a_o,          // Square wave A
    output logic wave_output_b_o,          // Square wave B
    output logic low_match_irq_o,          // Low match pulse
    output logic high_match_irq_o,         // High match pulse
    output logic irq_o                     // Enabled status level
);
    logic [2:0] timer_mode_control_reg;
    logic [7:0] count_clock_select_reg;
    logic wave_enable_a_reg;
    logic wave_enable_b_reg;
    logic oscillation_mode_bit_reg;
    logic [7:0] low_compare_reg;
    logic [7:0] high_compare_reg;
    logic [7:0] low_counter_reg;
    logic [7:0] high_counter_reg;
    logic [7:0] low_counter_next;
    logic [7:0] high_counter_next;
    logic [PRE_W-1:0] prescale_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_enable_reg;
    logic [1:0] irq_status_next;
    logic [1:0] irq_clear;
    logic [1:0] irq_enable_next;
    logic [31:0] read_mux;
    logic read_err;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic cascade;
    logic lo_tick;
    logic hi_tick;
    logic lo_match_evt;
    logic hi_match_evt;
    logic apb_setup;
    logic apb_write;

    // Tick exponent for a clock code: tick every 2^e main clocks, 0 = none
    function automatic logic [3:0] tick_exp(input logic [3:0] code,
                                            input logic osc_mode);
        logic [3:0] e;
        e = 4'h0;
        if (code >= CODE_INT_FIRST) begin
            if (code == CODE_INT_LAST) begin
                e = CODE_LAST_EXP;
            end else begin
                e = code - CODE_EXP_OFFSET;
            end
            if (!osc_mode) begin
                e = e + 4'h1;
            end
        end
        return e;
    endfunction : tick_exp

    // Count tick for one counter from its clock code
    function automatic logic code_tick(input logic [3:0] code,
                                       input logic osc_mode,
                                       input logic [PRE_W-1:0] pre,
                                       input logic rise,
                                       input logic fall);
        logic [3:0] e;
        logic [PRE_W:0] m;
        logic t;
        e = tick_exp(code, osc_mode);
        m = ({{PRE_W{1'b0}}, 1'b1} << e) - {{PRE_W{1'b0}}, 1'b1};
        t = 1'b0;
        if (code == CODE_EXT_FALL) begin
            t = fall;
        end else if (code == CODE_EXT_RISE) begin
            t = rise;
        end else if (e != 4'h0) begin
            t = (pre & m[PRE_W-1:0]) == m[PRE_W-1:0];
        end
        return t;
    endfunction : code_tick

    dce_edge_sync u_sync_a (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(event_input_a_i),
        .rise_o(a_rise),
        .fall_o(a_fall)
    );

    dce_edge_sync u_sync_b (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(event_input_b_i),
        .rise_o(b_rise),
        .fall_o(b_fall)
    );

    // Free-running divider of the main clock shared by both counters
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prescale_reg <= '0;
        end else begin
            prescale_reg <= prescale_reg + {{(PRE_W-1){1'b0}}, 1'b1};
        end
    end

    assign cascade = timer_mode_control_reg[MODE_CASCADE_BIT];

    always_comb begin
        lo_tick = timer_mode_control_reg[MODE_LO_EN_BIT]
            && code_tick(count_clock_select_reg[3:0],
                         oscillation_mode_bit_reg, prescale_reg,
                         a_rise, a_fall);
        hi_tick = !cascade && timer_mode_control_reg[MODE_HI_EN_BIT]
            && code_tick(count_clock_select_reg[7:4],
                         oscillation_mode_bit_reg, prescale_reg,
                         b_rise, b_fall);
    end

    // Counting and match; a cleared enable holds its counter at zero, except the high enable in cascade
    always_comb begin
        low_counter_next = low_counter_reg;
        high_counter_next = high_counter_reg;
        lo_match_evt = 1'b0;
        hi_match_evt = 1'b0;
        if (cascade) begin
            if (!timer_mode_control_reg[MODE_LO_EN_BIT]) begin
                low_counter_next = 8'h00;
                high_counter_next = 8'h00;
            end else if (lo_tick) begin
                lo_match_evt = low_counter_reg == low_compare_reg;
                if (lo_match_evt && high_counter_reg == high_compare_reg) begin
                    low_counter_next = 8'h00;
                    high_counter_next = 8'h00;
                    hi_match_evt = 1'b1;
                end else begin
                    low_counter_next = low_counter_reg + 8'h01;
                    if (low_counter_reg == 8'hff) begin
                        high_counter_next = high_counter_reg + 8'h01;
                    end
                end
            end
        end else begin
            if (!timer_mode_control_reg[MODE_LO_EN_BIT]) begin
                low_counter_next = 8'h00;
            end else if (lo_tick) begin
                if (low_counter_reg == low_compare_reg) begin
                    low_counter_next = 8'h00;
                    lo_match_evt = 1'b1;
                end else begin
                    low_counter_next = low_counter_reg + 8'h01;
                end
            end
            if (!timer_mode_control_reg[MODE_HI_EN_BIT]) begin
                high_counter_next = 8'h00;
            end else if (hi_tick) begin
                if (high_counter_reg == high_compare_reg) begin
                    high_counter_next = 8'h00;
                    hi_match_evt = 1'b1;
                end else begin
                    high_counter_next = high_counter_reg + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_counter_reg <= 8'h00;
            high_counter_reg <= 8'h00;
        end else begin
            low_counter_reg <= low_counter_next;
            high_counter_reg <= high_counter_next;
        end
    end

    // Square waves: half-period is (compare + 1) ticks, except wave A in cascade, which toggles at each low match
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wave_output_a_o <= 1'b0;
            wave_output_b_o <= 1'b0;
        end else begin
            if (wave_enable_a_reg && lo_match_evt) begin
                wave_output_a_o <= ~wave_output_a_o;
            end
            if (wave_enable_b_reg && hi_match_evt) begin
                wave_output_b_o <= ~wave_output_b_o;
            end
        end
    end

    // APB: setup cycle prepares the answer, access cycle completes it
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pready_o && pwrite_i;

    always_comb begin
        read_mux = 32'h0000_0000;
        read_err = 1'b0;
        unique case (paddr_i)
            OFS_MODE: read_mux[2:0] = timer_mode_control_reg;
            OFS_CLKSEL: read_mux[7:0] = count_clock_select_reg;
            OFS_WAVE: begin
                read_mux[WAVE_A_EN_BIT] = wave_enable_a_reg;
                read_mux[WAVE_B_EN_BIT] = wave_enable_b_reg;
            end
            OFS_OSC: read_mux[OSC_MODE_BIT] = oscillation_mode_bit_reg;
            OFS_LO_CMP: read_mux[7:0] = low_compare_reg;
            OFS_HI_CMP: read_mux[7:0] = high_compare_reg;
            // One word carries both bytes so a 16-bit read is coherent
            OFS_COUNT: read_mux[15:0] = {high_counter_reg,
                                         low_counter_reg};
            OFS_IRQ_STAT: read_mux[1:0] = irq_status_reg;
            OFS_IRQ_EN: read_mux[1:0] = irq_enable_reg;
            OFS_IRQ_CLR: read_mux = 32'h0000_0000;
            default: read_err = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= apb_setup;
            pslverr_o <= apb_setup && read_err;
            if (apb_setup && !pwrite_i) begin
                prdata_o <= read_mux;
            end else begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_mode_control_reg <= MODE_RST;
            count_clock_select_reg <= CLKSEL_RST;
            wave_enable_a_reg <= 1'b0;
            wave_enable_b_reg <= 1'b0;
            oscillation_mode_bit_reg <= OSC_RST;
            low_compare_reg <= CMP_RST;
            high_compare_reg <= CMP_RST;
        end else if (apb_write) begin
            if (paddr_i == OFS_MODE) begin
                timer_mode_control_reg <= pwdata_i[2:0];
            end
            if (paddr_i == OFS_CLKSEL) begin
                count_clock_select_reg <= pwdata_i[7:0];
            end
            if (paddr_i == OFS_WAVE) begin
                wave_enable_a_reg <= pwdata_i[WAVE_A_EN_BIT];
                wave_enable_b_reg <= pwdata_i[WAVE_B_EN_BIT];
            end
            if (paddr_i == OFS_OSC) begin
                oscillation_mode_bit_reg <= pwdata_i[OSC_MODE_BIT];
            end
            if (paddr_i == OFS_LO_CMP) begin
                low_compare_reg <= pwdata_i[7:0];
            end
            if (paddr_i == OFS_HI_CMP) begin
                high_compare_reg <= pwdata_i[7:0];
            end
        end
    end

    // Sticky status; a new event in the clearing cycle survives
    always_comb begin
        irq_clear = 2'h0;
        if (apb_write && paddr_i == OFS_IRQ_CLR) begin
            irq_clear = pwdata_i[1:0];
        end
        irq_status_next = irq_status_reg & ~irq_clear;
        irq_status_next[IRQ_LO_BIT] = irq_status_next[IRQ_LO_BIT]
            | lo_match_evt;
        irq_status_next[IRQ_HI_BIT] = irq_status_next[IRQ_HI_BIT]
            | hi_match_evt;
    end

    // Enable as it will stand after this edge, so a mask write moves
    // irq_o at the same edge as a status change would
    always_comb begin
        irq_enable_next = irq_enable_reg;
        if (apb_write && paddr_i == OFS_IRQ_EN) begin
            irq_enable_next = pwdata_i[1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_enable_reg <= IRQ_RST;
        end else begin
            irq_enable_reg <= irq_enable_next;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_status_reg <= IRQ_RST;
            irq_o <= 1'b0;
            low_match_irq_o <= 1'b0;
            high_match_irq_o <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            // Next state of both, so the level tracks them without lag
            irq_o <= |(irq_status_next & irq_enable_next);
            low_match_irq_o <= lo_match_evt;
            high_match_irq_o <= hi_match_evt;
        end
    end

endmodule : dce_timer

// File: verification/dce_timer_sva.sv
// Purpose: Port-level checks for the dual event timer.
// Assumes: One clock domain, zero-wait APB answers.
// Notes: Bound to dce_timer from the testbench top.
`timescale 1ns/10ps
module dce_timer_sva
    import dce_pkg::*;
(
    input wire logic ref_clk_i,            // Main clock
    input wire logic rst_n_i,              // Async reset, active low
    input wire logic psel_i,               // APB select
    input wire logic penable_i,            // APB enable
    input wire logic pwrite_i,             // APB direction
    input wire logic [ADDR_W-1:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i,      // APB write data
    input wire logic [31:0] prdata_o,      // APB read data
    input wire logic pready_o,             // APB ready
    input wire logic pslverr_o,            // APB error
    input wire logic event_input_a_i,      // Event pin A
    input wire logic event_input_b_i,      // Event pin B
    input wire logic wave_output_a_o,      // Square wave A
    input wire logic wave_output_b_o,      // Square wave B
    input wire logic low_match_irq_o,      // Low match pulse
    input wire logic high_match_irq_o,     // High match pulse
    input wire logic irq_o                 // Interrupt level
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic bad_addr;
    assign bad_addr = (paddr_i > OFS_IRQ_CLR) || (paddr_i[1:0] != 2'h0);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    a_ready_next: assert property (s_setup |=> pready_o)
        else $error("no ready after setup");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_err_match: assert property (s_setup |=> pslverr_o == $past(bad_addr))
        else $error("error flag does not follow the address");
    a_idle_data: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside access");
    a_wave_a_match: assert property ($changed(wave_output_a_o) |->
        low_match_irq_o) else $error("wave A moved without a low match");
    a_wave_b_match: assert property ($changed(wave_output_b_o) |->
        high_match_irq_o) else $error("wave B moved without a high match");
    a_low_gap: assert property (low_match_irq_o |=> !low_match_irq_o)
        else $error("low matches closer than the fastest tick");
    a_high_gap: assert property (high_match_irq_o |=> !high_match_irq_o)
        else $error("high matches closer than the fastest tick");
    a_irq_rise_cause: assert property ($rose(irq_o) |->
        low_match_irq_o || high_match_irq_o ||
        $past(psel_i && penable_i && pwrite_i))
        else $error("interrupt rose without a cause");
    a_irq_fall_cause: assert property ($fell(irq_o) |->
        $past(psel_i && penable_i && pwrite_i))
        else $error("interrupt fell without a write");
endmodule : dce_timer_sva

// File: verification/dce_pulse_src.sv
// Purpose: Behavioural source of event pulses for one timer pin.
// Assumes: Paced by the main clock; the pin idles low.
// Notes: WIDTH sets each level; the pin filter needs two clocks at least.
`timescale 1ns/10ps
module dce_pulse_src #(
    parameter int WIDTH = 3
) (
    input wire logic clk_i,     // Main clock
    input wire logic go_i,      // Start request, sampled at a rising edge
    input wire logic [7:0] n_i, // Number of pulses in the burst
    output logic pin_o,         // Event pin
    output logic busy_o         // High while a burst runs
);
    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i === 1'b1 && n_i != 8'h0) begin
                busy_o <= 1'b1;
                repeat (n_i) begin
                    repeat (WIDTH) @(posedge clk_i);
                    pin_o <= 1'b1;
                    repeat (WIDTH) @(posedge clk_i);
                    pin_o <= 1'b0;
                end
                repeat (WIDTH) @(posedge clk_i);
                busy_o <= 1'b0;
            end
        end
    end
endmodule : dce_pulse_src

// File: verification/tb.sv
// Purpose: Self-checking bench for the dual event timer.
// Assumes: Zero-wait APB slave, 40 MHz main clock.
// Notes: Pin bursts come from two pulse sources, one slow, one prompt.
`timescale 1ns/10ps
module tb;
    import dce_pkg::*;
    typedef struct {
        logic [7:0] sel;
        logic [7:0] lo_cmp;
        logic [7:0] hi_cmp;
        logic [7:0] n;
        logic [15:0] cnt;
        logic [1:0] stat;
        logic [7:0] lo_n;
        logic [7:0] hi_n;
    } dce_row_t;
    logic ref_clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ev_a, ev_b, wave_a, wave_b, irq_lo, irq_hi, irq, err, go;
    logic busy_a, busy_b;
    logic [7:0] n_pulse;
    logic [31:0] rst_exp [10];
    dce_row_t rows [4];
    int error_cnt, comparisons, gap, lo_seen, hi_seen, lo_base, hi_base;

    dce_timer u_dce_timer (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .event_input_a_i(ev_a),
        .event_input_b_i(ev_b), .wave_output_a_o(wave_a),
        .wave_output_b_o(wave_b), .low_match_irq_o(irq_lo),
        .high_match_irq_o(irq_hi), .irq_o(irq));
    dce_pulse_src #(.WIDTH(4)) u_src_a (.clk_i(ref_clk_i), .go_i(go),
        .n_i(n_pulse), .pin_o(ev_a), .busy_o(busy_a));
    dce_pulse_src #(.WIDTH(2)) u_src_b (.clk_i(ref_clk_i), .go_i(go),
        .n_i(n_pulse), .pin_o(ev_b), .busy_o(busy_b));

    // Match pulses seen, so each row can count them
    always @(posedge ref_clk_i) begin
        lo_seen <= lo_seen + int'(irq_lo === 1'b1);
        hi_seen <= hi_seen + int'(irq_hi === 1'b1);
    end

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask : chk

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        @(posedge ref_clk_i);
        // Flop outputs still hold the value sampled at the previous edge
        while (pready !== 1'b1) begin
            @(posedge ref_clk_i);
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd);
    endtask : wr

    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd);
        chk(nm, exp, rd);
    endtask : rdchk

    task automatic pulses(input logic [7:0] n);
        int k;
        k = 0;
        @(posedge ref_clk_i);
        n_pulse <= n;
        go <= 1'b1;
        @(posedge ref_clk_i);
        go <= 1'b0;
        @(negedge ref_clk_i);
        while ((busy_a === 1'b1 || busy_b === 1'b1) && k < 5000) begin
            @(negedge ref_clk_i);
            k++;
        end
        repeat (8) @(negedge ref_clk_i);
    endtask : pulses

    // Clocks between two changes of the chosen wave pin
    task automatic gap_of(input logic b, output int g);
        logic prev;
        int n;
        n = 0;
        g = 0;
        @(negedge ref_clk_i);
        prev = b ? wave_b : wave_a;
        while ((b ? wave_b : wave_a) === prev && n < 3000) begin
            @(negedge ref_clk_i);
            n++;
        end
        prev = b ? wave_b : wave_a;
        while ((b ? wave_b : wave_a) === prev && g < 3000) begin
            @(negedge ref_clk_i);
            g++;
        end
    endtask : gap_of

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    initial begin
        #400000;
        error_cnt++;
        finish_test;
    end

    initial begin
        rst_n_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        go = 1'b0;
        n_pulse = 8'h0;
        error_cnt = 0;
        comparisons = 0;
        rst_exp = '{32'(MODE_RST), 32'(CLKSEL_RST), 32'h0, 32'(OSC_RST),
            32'(CMP_RST), 32'(CMP_RST), 32'h0, 32'(IRQ_RST), 32'(IRQ_RST), 32'h0};
        // Codes: {high, low}; counts and status after the burst
        rows = '{'{8'h11, 8'd10, 8'd10, 8'd5, 16'h0505, 2'h0, 8'd0, 8'd0},
                 '{8'h00, 8'd2, 8'd3, 8'd5, 16'h0102, 2'h3, 8'd1, 8'd1},
                 '{8'h01, 8'd4, 8'd0, 8'd4, 16'h0004, 2'h2, 8'd0, 8'd4},
                 '{8'h52, 8'd0, 8'd0, 8'd3, 16'h0000, 2'h0, 8'd0, 8'd0}};
        repeat (20) @(posedge ref_clk_i);
        chk("irq in reset", 32'h0, {31'h0, irq});
        rst_n_i <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rdchk("reset value", 12'(i * 4), rst_exp[i]);
        end
        wr(OFS_COUNT, 32'h1234);
        rdchk("count after write", OFS_COUNT, 32'h0);
        rdchk("unmapped read", 12'h028, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("register test done");
        foreach (rows[i]) begin
            wr(OFS_MODE, 32'h0);
            wr(OFS_IRQ_CLR, 32'h3);
            wr(OFS_CLKSEL, {24'h0, rows[i].sel});
            wr(OFS_LO_CMP, {24'h0, rows[i].lo_cmp});
            wr(OFS_HI_CMP, {24'h0, rows[i].hi_cmp});
            wr(OFS_MODE, 32'h3);
            lo_base = lo_seen;
            hi_base = hi_seen;
            pulses(rows[i].n);
            rdchk("count", OFS_COUNT, {16'h0, rows[i].cnt});
            rdchk("status", OFS_IRQ_STAT, {30'h0, rows[i].stat});
            chk("lo pulses", {24'h0, rows[i].lo_n}, lo_seen - lo_base);
            chk("hi pulses", {24'h0, rows[i].hi_n}, hi_seen - hi_base);
            $display("event row %0d done", i);
        end
        wr(OFS_MODE, 32'h0);
        wr(OFS_IRQ_CLR, 32'h3);
        wr(OFS_OSC, 32'h1);
        wr(OFS_CLKSEL, 32'h06);
        wr(OFS_LO_CMP, 32'h1);
        wr(OFS_WAVE, 32'h11);
        wr(OFS_IRQ_EN, 32'h1);
        wr(OFS_MODE, 32'h1);
        gap_of(1'b0, gap);
        chk("wave gap fast", 32'd4, gap);
        chk("irq enabled", 32'h1, {31'h0, irq});
        wr(OFS_OSC, 32'h0);
        gap_of(1'b0, gap);
        gap_of(1'b0, gap);
        chk("wave gap slow", 32'd8, gap);
        wr(OFS_IRQ_EN, 32'h0);
        @(negedge ref_clk_i);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(OFS_MODE, 32'h0);
        wr(OFS_IRQ_CLR, 32'h1);
        rdchk("status cleared", OFS_IRQ_STAT, 32'h0);
        $display("wave test done");
        // High code left prohibited: the cascade must ignore it
        wr(OFS_OSC, 32'h1);
        wr(OFS_CLKSEL, 32'h26);
        wr(OFS_LO_CMP, 32'h3);
        wr(OFS_HI_CMP, 32'h1);
        wr(OFS_IRQ_EN, 32'h2);
        wr(OFS_MODE, 32'h6);
        repeat (40) @(negedge ref_clk_i);
        rdchk("cascade held", OFS_COUNT, 32'h0);
        wr(OFS_MODE, 32'h5);
        gap_of(1'b1, gap);
        gap_of(1'b1, gap);
        chk("cascade period", 32'd520, gap);
        rdchk("cascade status", OFS_IRQ_STAT, 32'h3);
        chk("high irq only", 32'h1, {31'h0, irq});
        $display("cascade test done");
        finish_test;
    end
endmodule : tb

bind dce_timer dce_timer_sva u_dce_timer_sva (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .event_input_a_i(event_input_a_i), .event_input_b_i(event_input_b_i),
    .wave_output_a_o(wave_output_a_o), .wave_output_b_o(wave_output_b_o),
    .low_match_irq_o(low_match_irq_o), .high_match_irq_o(high_match_irq_o),
    .irq_o(irq_o));
